// ===== cpu_regs_map.vh
// address map, register offsets, flag fields and reset values of the core register set
`ifndef CPU_REGS_MAP_VH
`define CPU_REGS_MAP_VH

// ------------------------------------------------------------
// memory map
// ------------------------------------------------------------
`define MAP_SFR_LO        20'h00000
`define MAP_SFR_HI        20'h003FF
`define MAP_RAM_LO        20'h00400
`define MAP_SPV_LO        20'hFFE00
`define MAP_SPV_HI        20'hFFFDB
`define MAP_FIXVEC_LO     20'hFFFDC
`define MAP_TOP           20'hFFFFF

// region codes reported by the decoder
`define RGN_SFR           3'h0
`define RGN_RAM           3'h1
`define RGN_ROM           3'h2
`define RGN_SPV           3'h3
`define RGN_FIXVEC        3'h4
`define RGN_NONE          3'h5

// ------------------------------------------------------------
// apb register offsets (byte addresses)
// ------------------------------------------------------------
`define OFS_DATA0         12'h000
`define OFS_DATA1         12'h004
`define OFS_DATA2         12'h008
`define OFS_DATA3         12'h00C
`define OFS_PTR0          12'h010
`define OFS_PTR1          12'h014
`define OFS_FRAME         12'h018
`define OFS_PC            12'h01C
`define OFS_VECBASE       12'h020
`define OFS_USP           12'h024
`define OFS_ISP           12'h028
`define OFS_STATIC        12'h02C
`define OFS_FLAGS         12'h030
`define OFS_ACTSP         12'h034
`define OFS_LONGLO        12'h038
`define OFS_LONGHI        12'h03C
`define OFS_PTRLONG       12'h040
`define OFS_DECODE        12'h044
`define OFS_EVENT         12'h048

// ------------------------------------------------------------
// flag register fields
// ------------------------------------------------------------
`define FLG_CARRY         0
`define FLG_DEBUG         1
`define FLG_ZERO          2
`define FLG_SIGN          3
`define FLG_BANK          4
`define FLG_OVFL          5
`define FLG_IEN           6
`define FLG_USTK          7
`define FLG_IPL_LO        12
`define FLG_IPL_HI        14
`define FLG_IMPL_MASK     16'h70FF
`define FLG_RESET         16'h0000

`define PC_RESET          20'h00000
`define VEC_RESET         20'h00000
`endif

// ===== addr_region_decode.v
// decodes a 20-bit core address into its memory map region
`timescale 1ns/100ps
`include "cpu_regs_map.vh"
module addr_region_decode #(
   parameter RAM_HI = 20'h01BFF,
   parameter ROM_LO = 20'hE8000
) (
   input  wire [19:0] addr,
   output reg  [2:0]  region
);
   // ------------------------------------------------------------
   // region decode
   // ------------------------------------------------------------
   // fixed vectors win over the special page, which wins over plain rom
   always @* begin
      if (addr <= `MAP_SFR_HI)
         region = `RGN_SFR;
      else if (addr >= `MAP_FIXVEC_LO)
         region = `RGN_FIXVEC;
      else if (addr >= `MAP_SPV_LO && addr <= `MAP_SPV_HI)
         region = `RGN_SPV;
      else if (addr >= ROM_LO)
         region = `RGN_ROM;
      else if (addr >= `MAP_RAM_LO && addr <= RAM_HI)
         region = `RGN_RAM;
      else
         region = `RGN_NONE;
   end
endmodule

// ===== flag_update.v
// computes the next flag word from alu results, events and software writes
`timescale 1ns/100ps
`include "cpu_regs_map.vh"
module flag_update (
   input  wire [15:0] flagsCur,
   input  wire        swWrite,
   input  wire [15:0] swData,
   input  wire        aluValid,
   input  wire [15:0] aluResult,
   input  wire        aluCarry,
   input  wire        aluOvfl,
   input  wire        intAck,
   input  wire        swIntLow,
   input  wire        stepAck,
   output reg  [15:0] flagsNext
);
   // ------------------------------------------------------------
   // flag next state
   // ------------------------------------------------------------
   // hardware events are applied after a software write so they win
   always @* begin
      flagsNext = flagsCur;
      if (swWrite)
         flagsNext = swData & `FLG_IMPL_MASK;
      if (aluValid) begin
         flagsNext[`FLG_CARRY] = aluCarry;
         flagsNext[`FLG_ZERO]  = (aluResult == 16'h0000);
         flagsNext[`FLG_SIGN]  = aluResult[15];
         flagsNext[`FLG_OVFL]  = aluOvfl;
      end
      if (stepAck)
         flagsNext[`FLG_DEBUG] = 1'b0;
      if (intAck) begin
         flagsNext[`FLG_IEN]  = 1'b0;
         flagsNext[`FLG_USTK] = 1'b0;
      end
      if (swIntLow)
         flagsNext[`FLG_USTK] = 1'b0;
      flagsNext = flagsNext & `FLG_IMPL_MASK;
   end
endmodule

// ===== cpu_register_set.v
// banked core register set with apb access, flag logic and map decode
//
// Function
// - decode 1 Mbyte space, rom from top
// - fixed vectors at FFFDC..FFFFF
// - ram starts at 00400 upward
// - sfr region 00000..003FF
// - special page vectors FFE00..FFFDB
// - thirteen registers, seven banked twice
// - four 16-bit data registers
// - first two data words split bytes
// - third:first and fourth:second form longs
// - two 16-bit pointers, pair second upper
// - 16-bit frame base register
// - 20-bit program counter
// - 20-bit vector table base
// - two stack pointers chosen by bit 7
// - 16-bit static base register
// - eleven flag bits, rest reserved
// - bit 0 holds alu carry
// - debug flag steps, cleared on acknowledge
// - bit 2 set on zero result
// - bit 3 set on negative result
// - bit 4 selects visible bank
// - bit 7 stack select, cleared by interrupts
// - priority level bits 12..14 gate interrupts
// - bit 6 enables interrupts, cleared on acknowledge
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/100ps
`include "cpu_regs_map.vh"
module cpu_register_set #(
   parameter RAM_HI = 20'h01BFF,
   parameter ROM_LO = 20'hE8000
) (
   input  wire        clk,
   input  wire        srst,
   input  wire        clkEn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // alu result port, same clock
   input  wire        aluValid,
   input  wire [15:0] aluResult,
   input  wire        aluCarry,
   input  wire        aluOvfl,
   // interrupt and step events, same clock
   input  wire        intReq,
   input  wire [2:0]  intLevel,
   input  wire        intMaskable,
   input  wire        intAck,
   input  wire        swIntLow,
   input  wire        instrDone,
   input  wire        stepAck,
   // outputs
   output reg         intAccept,
   output reg         stepIntReq,
   output reg  [15:0] activeStack,
   output reg  [2:0]  pcRegion,
   output reg         bankSel
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   localparam BANKED = 7;
   localparam IDX_PTR0  = 3'd4;
   localparam IDX_PTR1  = 3'd5;
   localparam IDX_FRAME = 3'd6;

   reg  [15:0] bankRegs [0:2*BANKED-1];   // index = bank*7 + register
   reg  [19:0] progCounter_q;
   reg  [19:0] vecBase_q;
   reg  [15:0] userStack_q;
   reg  [15:0] intStack_q;
   reg  [15:0] staticBase_q;
   reg  [15:0] flags_q;
   wire [15:0] flags_d;
   wire [2:0]  region;
   integer     i;

   wire        setupRd;
   wire        accWr;
   wire        bankNow;
   wire        hit;
   reg  [31:0] rdMux;
   reg         known;

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------
   // index of a banked register in the visible bank
   function [3:0] bankIdx;
      input       bank;
      input [2:0] slot;
      begin
         bankIdx = bank ? (4'd7 + {1'b0, slot}) : {1'b0, slot};
      end
   endfunction

   // merges byte lanes of a write into a 16-bit register
   function [15:0] laneMerge;
      input [15:0] old;
      input [15:0] nw;
      input [1:0]  lanes;
      begin
         laneMerge[7:0]  = lanes[0] ? nw[7:0]  : old[7:0];
         laneMerge[15:8] = lanes[1] ? nw[15:8] : old[15:8];
      end
   endfunction

   // merges byte lanes of a write into a 20-bit register
   function [19:0] laneMerge20;
      input [19:0] old;
      input [31:0] nw;
      input [3:0]  lanes;
      begin
         laneMerge20[7:0]   = lanes[0] ? nw[7:0]   : old[7:0];
         laneMerge20[15:8]  = lanes[1] ? nw[15:8]  : old[15:8];
         laneMerge20[19:16] = lanes[2] ? nw[19:16] : old[19:16];
      end
   endfunction

   assign bankNow = flags_q[`FLG_BANK];
   assign setupRd = psel & ~penable;
   assign accWr   = psel & penable & pwrite & pready & clkEn;

   // ------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------
   flag_update uFlags (
      .flagsCur  (flags_q),
      .swWrite   (accWr && paddr == `OFS_FLAGS),
      .swData    (laneMerge(flags_q, pwdata[15:0], pstrb[1:0])),
      .aluValid  (aluValid),
      .aluResult (aluResult),
      .aluCarry  (aluCarry),
      .aluOvfl   (aluOvfl),
      .intAck    (intAck),
      .swIntLow  (swIntLow),
      .stepAck   (stepAck),
      .flagsNext (flags_d)
   );

   addr_region_decode #(
      .RAM_HI (RAM_HI),
      .ROM_LO (ROM_LO)
   ) uDecode (
      .addr   (progCounter_q),
      .region (region)
   );

   // ------------------------------------------------------------
   // read decode
   // ------------------------------------------------------------
   // unmapped offsets read zero and flag an error
   always @* begin
      rdMux = 32'h00000000;
      known = 1'b1;
      case (paddr)
         `OFS_DATA0:   rdMux = {16'h0000, bankRegs[bankIdx(bankNow, 3'd0)]};
         `OFS_DATA1:   rdMux = {16'h0000, bankRegs[bankIdx(bankNow, 3'd1)]};
         `OFS_DATA2:   rdMux = {16'h0000, bankRegs[bankIdx(bankNow, 3'd2)]};
         `OFS_DATA3:   rdMux = {16'h0000, bankRegs[bankIdx(bankNow, 3'd3)]};
         `OFS_PTR0:    rdMux = {16'h0000, bankRegs[bankIdx(bankNow, IDX_PTR0)]};
         `OFS_PTR1:    rdMux = {16'h0000, bankRegs[bankIdx(bankNow, IDX_PTR1)]};
         `OFS_FRAME:   rdMux = {16'h0000, bankRegs[bankIdx(bankNow, IDX_FRAME)]};
         `OFS_PC:      rdMux = {12'h000, progCounter_q};
         `OFS_VECBASE: rdMux = {12'h000, vecBase_q};
         `OFS_USP:     rdMux = {16'h0000, userStack_q};
         `OFS_ISP:     rdMux = {16'h0000, intStack_q};
         `OFS_STATIC:  rdMux = {16'h0000, staticBase_q};
         `OFS_FLAGS:   rdMux = {16'h0000, flags_q & `FLG_IMPL_MASK};
         `OFS_ACTSP:   rdMux = {16'h0000, flags_q[`FLG_USTK] ? userStack_q : intStack_q};
         `OFS_LONGLO:  rdMux = {bankRegs[bankIdx(bankNow, 3'd2)],
                                bankRegs[bankIdx(bankNow, 3'd0)]};
         `OFS_LONGHI:  rdMux = {bankRegs[bankIdx(bankNow, 3'd3)],
                                bankRegs[bankIdx(bankNow, 3'd1)]};
         `OFS_PTRLONG: rdMux = {bankRegs[bankIdx(bankNow, IDX_PTR1)],
                                bankRegs[bankIdx(bankNow, IDX_PTR0)]};
         `OFS_DECODE:  rdMux = {29'h00000000, region};
         `OFS_EVENT:   rdMux = {30'h00000000, stepIntReq, intAccept};
         default: begin
            rdMux = 32'h00000000;
            known = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // apb handshake
   // ------------------------------------------------------------
   // no wait state: data is registered during setup, answered in access
   assign hit = psel & penable & pready;
   always @(posedge clk) begin
      if (srst) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clkEn) begin
         if (setupRd) begin
            prdata  <= pwrite ? 32'h00000000 : rdMux;
            pslverr <= ~known;
            pready  <= 1'b1;
         end else if (hit) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // banked registers
   // ------------------------------------------------------------
   // only the visible bank is ever written
   always @(posedge clk) begin
      if (srst) begin
         for (i = 0; i < 2*BANKED; i = i + 1)
            bankRegs[i] <= 16'h0000;
      end else if (clkEn && accWr && !pslverr) begin
         case (paddr)
            `OFS_DATA0, `OFS_DATA1, `OFS_DATA2, `OFS_DATA3, `OFS_PTR0, `OFS_PTR1,
            `OFS_FRAME: begin
               bankRegs[bankIdx(bankNow, paddr[4:2])] <=
                  laneMerge(bankRegs[bankIdx(bankNow, paddr[4:2])], pwdata[15:0],
                            pstrb[1:0]);
            end
            `OFS_LONGLO: begin
               bankRegs[bankIdx(bankNow, 3'd0)] <= pwdata[15:0];
               bankRegs[bankIdx(bankNow, 3'd2)] <= pwdata[31:16];
            end
            `OFS_LONGHI: begin
               bankRegs[bankIdx(bankNow, 3'd1)] <= pwdata[15:0];
               bankRegs[bankIdx(bankNow, 3'd3)] <= pwdata[31:16];
            end
            `OFS_PTRLONG: begin
               bankRegs[bankIdx(bankNow, IDX_PTR0)] <= pwdata[15:0];
               bankRegs[bankIdx(bankNow, IDX_PTR1)] <= pwdata[31:16];
            end
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // shared registers
   // ------------------------------------------------------------
   // these never look at the bank flag
   always @(posedge clk) begin
      if (srst) begin
         progCounter_q <= `PC_RESET;
         vecBase_q     <= `VEC_RESET;
         userStack_q   <= 16'h0000;
         intStack_q    <= 16'h0000;
         staticBase_q  <= 16'h0000;
         flags_q       <= `FLG_RESET;
      end else if (clkEn) begin
         flags_q <= flags_d;
         if (accWr) begin
            case (paddr)
               `OFS_PC:      progCounter_q <= laneMerge20(progCounter_q, pwdata, pstrb);
               `OFS_VECBASE: vecBase_q     <= laneMerge20(vecBase_q, pwdata, pstrb);
               `OFS_USP:     userStack_q   <= laneMerge(userStack_q, pwdata[15:0], pstrb[1:0]);
               `OFS_ISP:     intStack_q    <= laneMerge(intStack_q, pwdata[15:0], pstrb[1:0]);
               `OFS_STATIC:  staticBase_q  <= laneMerge(staticBase_q, pwdata[15:0], pstrb[1:0]);
               `OFS_ACTSP: begin
                  if (flags_q[`FLG_USTK])
                     userStack_q <= laneMerge(userStack_q, pwdata[15:0], pstrb[1:0]);
                  else
                     intStack_q  <= laneMerge(intStack_q, pwdata[15:0], pstrb[1:0]);
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // event outputs
   // ------------------------------------------------------------
   // acceptance needs enable for maskable sources and level above ipl
   always @(posedge clk) begin
      if (srst) begin
         intAccept   <= 1'b0;
         stepIntReq  <= 1'b0;
         activeStack <= 16'h0000;
         pcRegion    <= `RGN_SFR;
         bankSel     <= 1'b0;
      end else if (clkEn) begin
         intAccept   <= intReq && (!intMaskable || flags_q[`FLG_IEN]) &&
                        (intLevel > flags_q[`FLG_IPL_HI:`FLG_IPL_LO]);
         stepIntReq  <= instrDone & flags_q[`FLG_DEBUG];
         activeStack <= flags_q[`FLG_USTK] ? userStack_q : intStack_q;
         pcRegion    <= region;
         bankSel     <= bankNow;
      end
   end
endmodule

// ===== cpu_register_set_monitor.sv
// assertions on bus timing, flag events and clock enable of the register set
`timescale 1ns/100ps
// ----------------------------------------
// checker
// ----------------------------------------
module cpu_register_set_monitor (
   input logic        clk,
   input logic        srst,
   input logic        clkEn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [3:0]  pstrb,
   input logic        pready,
   input logic        pslverr,
   input logic        intReq,
   input logic [2:0]  intLevel,
   input logic        intMaskable,
   input logic        intAck,
   input logic        instrDone,
   input logic        stepAck,
   input logic        intAccept,
   input logic        stepIntReq,
   input logic [2:0]  pcRegion,
   input logic        bankSel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // bus phases as the slave sees them
   wire setup = psel & ~penable & clkEn;
   wire done  = psel & penable & pready & clkEn;

   property p_ready_after_setup;
      setup |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup)
      else $error("ready missing after setup");
   property p_ready_drops;
      done |=> !pready;
   endproperty
   a_ready_drops: assert property (p_ready_drops)
      else $error("ready held after completion");
   property p_unmapped_err;
      pready & psel & (paddr > 12'h048) |-> pslverr;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("unmapped offset without error");
   property p_mapped_ok;
      pready & psel & (paddr <= 12'h048) & (paddr[1:0] == 2'b00) |-> !pslverr;
   endproperty
   a_mapped_ok: assert property (p_mapped_ok)
      else $error("mapped offset answered with error");
   // two cycles allow bankSel to trail the flag word by one register
   property p_bank_follows;
      done & pwrite & (paddr == 12'h030) & pstrb[0] |-> ##2 (bankSel == $past(pwdata[4], 2));
   endproperty
   a_bank_follows: assert property (p_bank_follows)
      else $error("bank select differs from written flag");
   property p_step_idle;
      clkEn & !instrDone |=> !stepIntReq;
   endproperty
   a_step_idle: assert property (p_step_idle)
      else $error("step request without finished instruction");
   property p_step_cleared;
      clkEn & stepAck ##1 !psel ##1 clkEn & instrDone |=> !stepIntReq;
   endproperty
   a_step_cleared: assert property (p_step_cleared)
      else $error("step request after acknowledge");
   property p_accept_idle;
      clkEn & (!intReq | (intLevel == 3'h0)) |=> !intAccept;
   endproperty
   a_accept_idle: assert property (p_accept_idle)
      else $error("interrupt accepted at level zero or idle");
   property p_ack_masks;
      clkEn & intAck ##1 !psel ##1 clkEn & intMaskable |=> !intAccept;
   endproperty
   a_ack_masks: assert property (p_ack_masks)
      else $error("maskable accepted after acknowledge");
   property p_freeze;
      !clkEn |=> $stable(bankSel) && $stable(pcRegion) && $stable(pready);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock enable low");
endmodule

bind cpu_register_set cpu_register_set_monitor cpu_register_set_monitor_inst (
   .clk, .srst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
   .pslverr, .intReq, .intLevel, .intMaskable, .intAck, .instrDone, .stepAck,
   .intAccept, .stepIntReq, .pcRegion, .bankSel);

// ===== tb_top.sv
// self-checking bench for the banked core register set
`timescale 1ns/100ps
`include "cpu_regs_map.vh"
module tb_top;
// ----------------------------------------
// signals and design
// ----------------------------------------
logic        clk, srst, clkEn, psel, penable, pwrite, pready, pslverr, e;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, r, x, rnd;
logic [3:0]  pstrb;
logic        aluValid, aluCarry, aluOvfl, intReq, intMaskable;
logic        intAck, swIntLow, instrDone, stepAck, intAccept, stepIntReq, bankSel;
logic [15:0] aluResult, activeStack, res;
logic [2:0]  intLevel, pcRegion;
logic [31:0] mir [0:11];
logic [19:0] pcv [0:10] = '{20'h00000, 20'h003FF, 20'h00400, 20'h01BFF, 20'h01C00,
   20'hE7FFF, 20'hE8000, 20'hFFE00, 20'hFFFDB, 20'hFFFDC, 20'hFFFFF};
logic [2:0]  rgn [0:10] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h5, 3'h5, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4};
integer      fails, checks_done, i, k;
integer      cyc = 0;

cpu_register_set cpu_register_set_inst (
   .clk, .srst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .pready, .pslverr, .aluValid, .aluResult, .aluCarry, .aluOvfl,
   .intReq, .intLevel, .intMaskable, .intAck, .swIntLow, .instrDone,
   .stepAck, .intAccept, .stepIntReq, .activeStack, .pcRegion, .bankSel);

// clock and hang guard
initial begin
   clk = 0;
   forever #2.5 clk = ~clk;
end
always @(posedge clk) begin
   cyc <= cyc + 1;
   if (cyc == 20000) begin
      fails = fails + 1;
      final_report;
   end
end
// ----------------------------------------
// tasks
// ----------------------------------------
task final_report;
   if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
   else
      $display("SIMULATION FAILED");
   $finish;
endtask
task chk(input [31:0] got, input [31:0] exp);
   checks_done = checks_done + 1;
   if (got !== exp) begin
      fails = fails + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
   end
endtask
// holds the request until pready; one idle edge after so psel is never set twice
task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
   {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
   @(posedge clk);
   penable <= 1;
   do @(posedge clk); while (pready !== 1'b1);
   r = prdata;
   e = pslverr;
   {psel, penable} <= 2'b00;
   @(posedge clk);
endtask
task wr(input [11:0] a, input [31:0] d);
   apb(1, a, d, 4'hF);
endtask
task rdchk(input [11:0] a, input [31:0] exp);
   apb(0, a, 32'h0, 4'hF);
   chk(r, exp);
endtask
// event order: alu, int ack, soft int, instr done, step ack
task pulse(input [4:0] m);
   {aluValid, intAck, swIntLow, instrDone, stepAck} <= m;
   @(posedge clk);
   {aluValid, intAck, swIntLow, instrDone, stepAck} <= 5'h0;
   @(posedge clk);
endtask
function [31:0] lfsr(input [31:0] v);
   lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
// carry, zero, sign and overflow replaced, other flags kept
function [15:0] aluf(input [15:0] f, input [15:0] q, input c, input o);
   aluf = (f & 16'hFFD2) | {10'h0, o, 1'b0, q[15], q == 16'h0, 1'b0, c};
endfunction
// ----------------------------------------
// scenarios
// ----------------------------------------
initial begin
   {fails, checks_done, rnd, srst, clkEn} = {64'h0, 32'h782A, 2'b11};
   {psel, penable, pwrite, paddr, pwdata, pstrb, aluResult, intLevel} = 0;
   {aluValid, intAck, swIntLow, instrDone, stepAck, aluCarry, aluOvfl, intReq} = 0;
   intMaskable = 1;
   repeat (10) @(posedge clk);
   srst <= 0;
   for (i = 0; i <= 18; i = i + 1)
      rdchk({i[9:0], 2'b00}, 32'h0);
   apb(0, 12'h04C, 32'h0, 4'hF);
   chk(r, 32'h0);
   chk({31'h0, e}, 32'h1);
   // all ones first to expose width faults, then random words
   for (k = 0; k < 2; k = k + 1) begin
      for (i = 0; i < 12; i = i + 1) begin
         rnd = k ? lfsr(rnd) : 32'hFFFFFFFF;
         mir[i] = rnd & ((i == 7 || i == 8) ? 32'hFFFFF : 32'hFFFF);
         wr({i[9:0], 2'b00}, rnd);
      end
      for (i = 0; i < 12; i = i + 1)
         rdchk({i[9:0], 2'b00}, mir[i]);
   end
   rdchk(`OFS_LONGLO, {mir[2][15:0], mir[0][15:0]});
   rdchk(`OFS_LONGHI, {mir[3][15:0], mir[1][15:0]});
   rdchk(`OFS_PTRLONG, {mir[5][15:0], mir[4][15:0]});
   apb(1, `OFS_DATA0, ~mir[0], 4'h1);
   rdchk(`OFS_DATA0, {mir[0][15:8], ~mir[0][7:0]});
   wr(`OFS_DATA0, mir[0]);
   // bank 1 holds its own copy; shared registers must not move
   wr(`OFS_FLAGS, 32'h10);
   rdchk(`OFS_DATA0, 32'h0);
   wr(`OFS_DATA0, 32'h5A5A);
   rdchk(`OFS_PC, mir[7]);
   chk(bankSel, 1);
   wr(`OFS_FLAGS, 32'h0);
   rdchk(`OFS_DATA0, mir[0]);
   wr(`OFS_FLAGS, 32'h80);
   // the stack output trails the flag word by one register
   @(posedge clk);
   chk(activeStack, mir[9]);
   wr(`OFS_FLAGS, 32'h0);
   rdchk(`OFS_ACTSP, mir[10]);
   wr(`OFS_FLAGS, 32'hC0);
   pulse(5'b01000);
   rdchk(`OFS_FLAGS, 32'h0);
   wr(`OFS_FLAGS, 32'h80);
   pulse(5'b00100);
   rdchk(`OFS_FLAGS, 32'h0);
   wr(`OFS_FLAGS, 32'hFFFFFFFF);
   rdchk(`OFS_FLAGS, 32'h70FF);
   // priority 3, interrupts enabled: only levels 4..7 pass
   wr(`OFS_FLAGS, 32'h3040);
   intReq <= 1;
   for (i = 0; i < 8; i = i + 1) begin
      intLevel <= i[2:0];
      repeat (2) @(posedge clk);
      chk(intAccept, i > 3);
   end
   wr(`OFS_FLAGS, 32'h3000);
   @(posedge clk);
   chk(intAccept, 0);
   intMaskable <= 0;
   repeat (2) @(posedge clk);
   chk(intAccept, 1);
   {intReq, intMaskable} <= 2'b01;
   wr(`OFS_FLAGS, 32'h2);
   pulse(5'b00010);
   chk(stepIntReq, 1);
   pulse(5'b00001);
   pulse(5'b00010);
   chk(stepIntReq, 0);
   x = 0;
   for (i = 0; i < 10; i = i + 1) begin
      rnd = lfsr(rnd);
      res = (i == 0) ? 16'h0 : (i == 1) ? 16'h8000 : rnd[15:0];
      {aluResult, aluCarry, aluOvfl} <= {res, rnd[17:16]};
      pulse(5'b10000);
      x = {16'h0, aluf(x[15:0], res, rnd[17], rnd[16])};
      rdchk(`OFS_FLAGS, x);
   end
   // a frozen core ignores the alu strobe
   clkEn <= 0;
   aluResult <= ~x[15:0];
   pulse(5'b10000);
   clkEn <= 1;
   rdchk(`OFS_FLAGS, x);
   for (i = 0; i < 11; i = i + 1) begin
      wr(`OFS_PC, {12'h0, pcv[i]});
      @(posedge clk);
      chk(pcRegion, rgn[i]);
   end
   final_report;
end
endmodule
